// *** verilog/vts_defines.svh ***
// offsets, field positions, reset values and bus codes of the trip select block
// assumes inclusion by bare name from each design file that needs a constant
//
// Contract
// - bit 7 and bits 3..0 read zero
// - detect select bit 6 is write-once
// - detect bit picks low or high trip
// - warning field bits 5..4 picks four thresholds
// - later writes to locked bit are ignored
`ifndef VTS_DEFINES_SVH
`define VTS_DEFINES_SVH

// byte addresses of the word registers
`define VTS_TRIP_SELECT_OFFSET 8'h00
`define VTS_LOCK_STATUS_OFFSET 8'h04
`define VTS_TRIP_DECODE_OFFSET 8'h08
`define VTS_ADDR_BITS 8

// fields of voltage_trip_select
`define VTS_DETECT_BIT 6
`define VTS_WARNING_HI 5
`define VTS_WARNING_LO 4
`define VTS_REG_WIDTH 8

// fields of the status and decode words
`define VTS_LOCK_BIT 0
`define VTS_DETECT_TRIP_LO 0
`define VTS_WARNING_TRIP_LO 4

// reset values
`define VTS_DETECT_RESET 1'h0
`define VTS_WARNING_RESET 2'h0
`define VTS_HRDATA_RESET 32'h0000_0000

// bus codes
`define VTS_HRESP_OKAY 1'h0
`define VTS_HTRANS_ACTIVE_BIT 1

`endif

// *** verilog/vts_pkg.sv ***
// types shared by the trip select top and its register core
// assumes the defines header is compiled alongside
package vts_pkg;

  // bus slave phases, one-hot
  typedef enum logic [3:0] {
    VTS_IDLE = 4'h1,
    VTS_WRITE = 4'h2,
    VTS_READ_WAIT = 4'h4,
    VTS_READ_DONE = 4'h8
  } vts_bus_state_type;

  typedef logic [1:0] vts_warning_level_type;

  typedef logic [7:0] vts_reg_type;

endpackage

// *** verilog/vts_reg_if.sv ***
// carrier between the bus slave and the trip select register core
// assumes both ends run on sys_clk_in
`timescale 1ns/1ps

interface vts_reg_if;
  logic wr_stb;
  vts_pkg::vts_reg_type wr_data;
  vts_pkg::vts_reg_type reg_value;
  logic detect_level;
  vts_pkg::vts_warning_level_type warning_level;
  logic detect_locked;

  modport core (
    input wr_stb,
    input wr_data,
    output reg_value,
    output detect_level,
    output warning_level,
    output detect_locked
  );

  modport host (
    output wr_stb,
    output wr_data,
    input reg_value,
    input detect_level,
    input warning_level,
    input detect_locked
  );
endinterface

// *** verilog/vts_reg_core.sv ***
// voltage_trip_select storage: write-once detect select, free warning field
// assumes one write strobe per accepted bus write, synchronous reset
`timescale 1ns/1ps
`include "vts_defines.svh"

module vts_reg_core (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  vts_reg_if.core reg_bus
);

  logic detect_level;
  vts_pkg::vts_warning_level_type warning_level;
  logic detect_locked;

  ////////////////////////////////////////////////////////////////////////////////
  // next values

  wire logic next_detect_level;
  wire vts_pkg::vts_warning_level_type next_warning_level;
  wire logic next_detect_locked;

  // first write after reset fixes the bit, later ones leave it alone
  assign next_detect_level = (reg_bus.wr_stb && !detect_locked) ?
    reg_bus.wr_data[`VTS_DETECT_BIT] : detect_level;
  assign next_detect_locked = detect_locked | reg_bus.wr_stb;
  assign next_warning_level = reg_bus.wr_stb ?
    reg_bus.wr_data[`VTS_WARNING_HI:`VTS_WARNING_LO] : warning_level;

  ////////////////////////////////////////////////////////////////////////////////
  // storage

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      detect_level <= `VTS_DETECT_RESET;
      warning_level <= `VTS_WARNING_RESET;
      detect_locked <= 1'h0;
    end else begin
      detect_level <= next_detect_level;
      warning_level <= next_warning_level;
      detect_locked <= next_detect_locked;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // readback, reserved bits tied low

  assign reg_bus.reg_value = {1'h0, detect_level, warning_level, 4'h0};
  assign reg_bus.detect_level = detect_level;
  assign reg_bus.warning_level = warning_level;
  assign reg_bus.detect_locked = detect_locked;

endmodule

// *** verilog/vts_trip_select_top.sv ***
// AHB-Lite slave holding the supply trip point select register
// assumes a single master, word transfers, all inputs on sys_clk_in
// assumes hready_in is the bus ready that this slave's hreadyout drives
// assumes only haddr bits 7:0 matter, so the block repeats every 256 bytes
//
// The AHB-Lite register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`include "vts_defines.svh"

module vts_trip_select_top #(
  parameter int WARNING_LEVELS = 4
) (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic hreadyout_out,
  output logic [31:0] hrdata_out,
  output logic hresp_out,
  output logic detect_level_select_out,
  output logic [1:0] warning_level_select_out,
  output logic detect_level_locked_out,
  output logic [1:0] detect_trip_point_out,
  output logic [WARNING_LEVELS-1:0] warning_trip_point_out
);

  ////////////////////////////////////////////////////////////////////////////////
  // register core

  vts_reg_if reg_link ();

  vts_reg_core core_inst (
    .sys_clk_in(sys_clk_in),
    .rst_in(rst_in),
    .reg_bus(reg_link.core)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // bus phase state

  vts_pkg::vts_bus_state_type bus_state;
  logic [`VTS_ADDR_BITS-1:0] phase_addr;
  logic [2:0] phase_size;
  logic hreadyout;
  logic [31:0] hrdata;
  logic hresp;

  ////////////////////////////////////////////////////////////////////////////////
  // address phase decode

  wire logic transfer_active;
  wire logic transfer_taken;
  wire logic write_taken;
  wire logic read_taken;

  assign transfer_active = hsel_in && htrans_in[`VTS_HTRANS_ACTIVE_BIT];
  // a transfer is taken when selected, active and the bus is ready
  assign transfer_taken = transfer_active && hready_in;
  assign write_taken = transfer_taken && hwrite_in;
  assign read_taken = transfer_taken && !hwrite_in;

  ////////////////////////////////////////////////////////////////////////////////
  // data phase decode

  wire logic hit_trip_select;
  wire logic hit_lock_status;
  wire logic hit_trip_decode;
  wire logic size_covers_low_byte;

  assign hit_trip_select = (phase_addr == `VTS_TRIP_SELECT_OFFSET);
  assign hit_lock_status = (phase_addr == `VTS_LOCK_STATUS_OFFSET);
  assign hit_trip_decode = (phase_addr == `VTS_TRIP_DECODE_OFFSET);
  // byte, half and word accesses at an aligned word all reach lane 0
  assign size_covers_low_byte = (phase_size <= 3'h2);

  ////////////////////////////////////////////////////////////////////////////////
  // next bus state

  vts_pkg::vts_bus_state_type next_bus_state;
  logic next_hreadyout;

  always_comb begin
    next_bus_state = bus_state;
    next_hreadyout = hreadyout;
    unique case (bus_state)
      vts_pkg::VTS_IDLE, vts_pkg::VTS_WRITE, vts_pkg::VTS_READ_DONE: begin
        if (write_taken) begin
          next_bus_state = vts_pkg::VTS_WRITE;
          next_hreadyout = 1'h1;
        end else if (read_taken) begin
          // one wait state lets a write in the prior data phase reach the register core; the trip decode word still lags one cycle
          next_bus_state = vts_pkg::VTS_READ_WAIT;
          next_hreadyout = 1'h0;
        end else begin
          next_bus_state = vts_pkg::VTS_IDLE;
          next_hreadyout = 1'h1;
        end
      end
      vts_pkg::VTS_READ_WAIT: begin
        // ready again with the loaded word
        next_bus_state = vts_pkg::VTS_READ_DONE;
        next_hreadyout = 1'h1;
      end
      default: begin
        next_bus_state = vts_pkg::VTS_IDLE;
        next_hreadyout = 1'h1;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // write path

  wire logic write_data_phase;
  wire logic write_to_trip_select;
  wire vts_pkg::vts_reg_type write_byte;

  assign write_data_phase = (bus_state == vts_pkg::VTS_WRITE);
  // writes elsewhere and to reserved bits change nothing
  assign write_to_trip_select = write_data_phase && hit_trip_select &&
    size_covers_low_byte;
  // an aligned register always sits on the low byte lane
  assign write_byte = hwdata_in[`VTS_REG_WIDTH-1:0];
  assign reg_link.wr_stb = write_to_trip_select;
  assign reg_link.wr_data = write_byte;

  ////////////////////////////////////////////////////////////////////////////////
  // read path

  wire logic [31:0] trip_select_word;
  wire logic [31:0] lock_status_word;
  wire logic [31:0] trip_decode_word;
  wire logic [31:0] read_word;
  wire logic [31:0] next_hrdata;

  assign trip_select_word = {24'h00_0000, reg_link.reg_value};
  // status word: bit 0 is the detect lock
  assign lock_status_word = {31'h0000_0000, reg_link.detect_locked};
  assign trip_decode_word = {{(32 - `VTS_WARNING_TRIP_LO - WARNING_LEVELS){1'h0}},
    warning_trip_point_out, 2'h0, detect_trip_point_out};

  // unmapped addresses read zero with an OKAY response
  assign read_word = hit_trip_select ? trip_select_word :
    hit_lock_status ? lock_status_word :
    hit_trip_decode ? trip_decode_word : 32'h0000_0000;

  wire logic read_data_load;

  // the wait state gives the register core a cycle after a write lands
  assign read_data_load = (bus_state == vts_pkg::VTS_READ_WAIT);
  assign next_hrdata = read_data_load ? read_word : hrdata;

  ////////////////////////////////////////////////////////////////////////////////
  // bus registers

  wire logic [`VTS_ADDR_BITS-1:0] next_phase_addr;
  wire logic [2:0] next_phase_size;
  wire logic next_hresp;

  // only the low address byte is kept, so the map repeats every 256 bytes
  assign next_phase_addr = transfer_taken ? haddr_in[`VTS_ADDR_BITS-1:0] : phase_addr;
  assign next_phase_size = transfer_taken ? hsize_in : phase_size;
  // no access is ever refused, so the two-cycle error response is never needed
  assign next_hresp = `VTS_HRESP_OKAY;

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      bus_state <= vts_pkg::VTS_IDLE;
    end else begin
      bus_state <= next_bus_state;
    end
  end

  // ready out of reset, so the first address phase is taken at once
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      hreadyout <= 1'h1;
    end else begin
      hreadyout <= next_hreadyout;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      phase_addr <= {`VTS_ADDR_BITS{1'h0}};
      phase_size <= 3'h0;
    end else begin
      phase_addr <= next_phase_addr;
      phase_size <= next_phase_size;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      hrdata <= `VTS_HRDATA_RESET;
    end else begin
      hrdata <= next_hrdata;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      hresp <= `VTS_HRESP_OKAY;
    end else begin
      hresp <= next_hresp;
    end
  end

  assign hreadyout_out = hreadyout;
  assign hrdata_out = hrdata;
  assign hresp_out = hresp;

  ////////////////////////////////////////////////////////////////////////////////
  // monitor selections, registered toward the analog side

  wire logic next_detect_level_select;
  wire vts_pkg::vts_warning_level_type next_warning_level_select;
  wire logic next_detect_level_locked;
  logic detect_level_select;
  logic [1:0] warning_level_select;
  logic detect_level_locked;

  assign next_detect_level_select = reg_link.detect_level;
  assign next_warning_level_select = reg_link.warning_level;
  assign next_detect_level_locked = reg_link.detect_locked;

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      detect_level_select <= `VTS_DETECT_RESET;
    end else begin
      detect_level_select <= next_detect_level_select;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      warning_level_select <= `VTS_WARNING_RESET;
    end else begin
      warning_level_select <= next_warning_level_select;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      detect_level_locked <= 1'h0;
    end else begin
      detect_level_locked <= next_detect_level_locked;
    end
  end

  assign detect_level_select_out = detect_level_select;
  assign warning_level_select_out = warning_level_select;
  assign detect_level_locked_out = detect_level_locked;

  ////////////////////////////////////////////////////////////////////////////////
  // detect trip point: bit 0 low trip, bit 1 high trip

  wire logic detect_trip_low;
  wire logic detect_trip_high;
  wire logic [1:0] next_detect_trip;
  logic [1:0] detect_trip;

  // exactly one of the two trip lines is high at any time
  assign detect_trip_low = !reg_link.detect_level;
  assign detect_trip_high = reg_link.detect_level;
  assign next_detect_trip = {detect_trip_high, detect_trip_low};

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      detect_trip <= {`VTS_DETECT_RESET, !`VTS_DETECT_RESET};
    end else begin
      detect_trip <= next_detect_trip;
    end
  end

  assign detect_trip_point_out = detect_trip;

  ////////////////////////////////////////////////////////////////////////////////
  // warning trip point: one line per threshold, lowest first

  logic [WARNING_LEVELS-1:0] warning_trip;

  genvar level;
  generate
    for (level = 0; level < WARNING_LEVELS; level++) begin : g_warning
      wire logic next_warning_trip;
      wire logic warning_trip_reset;

      assign next_warning_trip = (reg_link.warning_level == 2'(level));
      assign warning_trip_reset = (`VTS_WARNING_RESET == 2'(level));

      always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
          warning_trip[level] <= warning_trip_reset;
        end else begin
          warning_trip[level] <= next_warning_trip;
        end
      end
    end
  endgenerate

  assign warning_trip_point_out = warning_trip;

endmodule

// *** test/vts_trip_select_assertions.sv ***
// port assertions for the trip select top
// assumes a bind from the bench and a single clock domain
`timescale 1ns/1ps
module vts_trip_select_assertions #(
  parameter int WARNING_LEVELS = 4
) (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic hsel_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic hready_in,
  input wire logic hreadyout_out,
  input wire logic hresp_out,
  input wire logic detect_level_select_out,
  input wire logic [1:0] warning_level_select_out,
  input wire logic detect_level_locked_out,
  input wire logic [1:0] detect_trip_point_out,
  input wire logic [WARNING_LEVELS-1:0] warning_trip_point_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);
  wire logic rd_take = hsel_in && htrans_in[1] && hready_in && !hwrite_in;
  wire logic [1:0] det_hot = {detect_level_select_out, !detect_level_select_out};
  wire logic [WARNING_LEVELS-1:0] warn_hot =
    {{(WARNING_LEVELS-1){1'b0}}, 1'b1} << warning_level_select_out;
  //////////////////////////////////////////////////////////////////////////////
  read_wait_a: assert property (rd_take |=> !hreadyout_out ##1 hreadyout_out)
    else $error("read wait is not one cycle");
  okay_resp_a: assert property (hresp_out == 1'b0)
    else $error("response is not okay");
  detect_decode_a: assert property (
    detect_trip_point_out == det_hot || detect_trip_point_out == $past(det_hot))
    else $error("detect trip point does not follow select");
  warn_decode_a: assert property (
    warning_trip_point_out == warn_hot || warning_trip_point_out == $past(warn_hot))
    else $error("warning trip point does not follow field");
  lock_sticky_a: assert property (detect_level_locked_out |=> detect_level_locked_out)
    else $error("detect lock dropped without reset");
  lock_freeze_a: assert property (
    detect_level_locked_out |=> $stable(detect_level_select_out))
    else $error("locked detect select changed");
  unlocked_hold_a: assert property (
    !detect_level_locked_out |=> $stable(detect_level_select_out) || detect_level_locked_out)
    else $error("detect select changed without locking");
  reset_defaults_a: assert property (@(posedge sys_clk_in) disable iff (1'b0)
    rst_in ##1 rst_in |=> !detect_level_locked_out && !detect_level_select_out &&
    warning_level_select_out == 2'h0)
    else $error("reset did not restore defaults");
endmodule

// *** test/tb_top.sv ***
// self-checking bench for the trip select top over AHB-Lite
// assumes the design files and the checker are compiled first
`timescale 1ns/1ps
module tb_top;
  localparam int WARNING_LEVELS = 4;
  logic sys_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic hsel_in = 1'b0;
  logic [31:0] haddr_in = 32'h0;
  logic [1:0] htrans_in = 2'h0;
  logic hwrite_in = 1'b0;
  logic [2:0] hsize_in = 3'h2;
  logic [31:0] hwdata_in = 32'h0;
  wire logic hready_in, hreadyout_out, hresp_out;
  wire logic detect_level_select_out, detect_level_locked_out;
  wire logic [31:0] hrdata_out;
  wire logic [1:0] warning_level_select_out, detect_trip_point_out;
  wire logic [3:0] warning_trip_point_out;
  logic rd_phase = 1'b0;
  logic exp_sel, exp_lock;
  logic [1:0] exp_warn;
  logic [41:0] got_exp;
  logic [41:0] notes[$];
  logic [31:0] d;
  int n_errors = 0;
  int checks = 0;
  int seed = 21;
  assign hready_in = hreadyout_out;
  vts_trip_select_top #(.WARNING_LEVELS(WARNING_LEVELS)) i_vts_trip_select_top (
    .sys_clk_in, .rst_in, .hsel_in, .haddr_in, .htrans_in, .hwrite_in, .hsize_in,
    .hwdata_in, .hready_in, .hreadyout_out, .hrdata_out, .hresp_out,
    .detect_level_select_out, .warning_level_select_out, .detect_level_locked_out,
    .detect_trip_point_out, .warning_trip_point_out);
  initial begin
    forever #20 sys_clk_in = ~sys_clk_in;
  end
  //////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] exp_rd(input logic [7:0] a);
    case (a)
      8'h00: exp_rd = {25'h0, exp_sel, exp_warn, 4'h0};
      8'h04: exp_rd = {31'h0, exp_lock};
      8'h08: exp_rd = {24'h0, 4'h1 << exp_warn, 2'h0, exp_sel, !exp_sel};
      default: exp_rd = 32'h0;
    endcase
  endfunction
  task wait_ready;
    int n;
    n = 0;
    do begin
      @(posedge sys_clk_in);
      n++;
    end while (hready_in !== 1'b1 && n < 50);
    if (n >= 50) begin
      $display("MISMATCH %0t no ready", $time);
      n_errors++;
    end
  endtask
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
    if (!w) notes.push_back({exp_rd(a), exp_lock, exp_sel, exp_warn, exp_sel, !exp_sel,
      4'h1 << exp_warn});
    @(posedge sys_clk_in);
    hsel_in <= 1'b1;
    htrans_in <= 2'h2;
    haddr_in <= {24'h0, a};
    hwrite_in <= w;
    wait_ready();
    hsel_in <= 1'b0;
    htrans_in <= 2'h0;
    hwdata_in <= wd;
    rd_phase <= !w;
    wait_ready();
    rd_phase <= 1'b0;
    if (w && a == 8'h00) begin
      if (!exp_lock) exp_sel = wd[6];
      exp_lock = 1'b1;
      exp_warn = wd[5:4];
    end
  endtask
  task rd_all;
    xfer(1'b0, 8'h00, 32'h0);
    xfer(1'b0, 8'h04, 32'h0);
    xfer(1'b0, 8'h08, 32'h0);
    xfer(1'b0, 8'h0C, 32'h0);
    xfer(1'b0, 8'hFC, 32'h0);
  endtask
  task tally_and_finish;
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  always @(posedge sys_clk_in) begin
    if (rd_phase && hreadyout_out === 1'b1) begin
      checks++;
      got_exp = notes.pop_front();
      if ({hrdata_out, detect_level_locked_out, detect_level_select_out,
        warning_level_select_out, detect_trip_point_out, warning_trip_point_out} !== got_exp) begin
        $display("MISMATCH %0t read %h expected %h", $time, hrdata_out, got_exp[41:10]);
        n_errors++;
      end
    end
  end
  initial begin
    #(40 * 4000);
    $display("MISMATCH %0t watchdog expired", $time);
    n_errors++;
    tally_and_finish();
  end
  initial begin
    repeat (16) @(posedge sys_clk_in);
    rst_in <= 1'b0;
    for (int p = 0; p < 2; p++) begin
      if (p == 1) begin
        @(posedge sys_clk_in);
        rst_in <= 1'b1;
        repeat (2) @(posedge sys_clk_in);
        rst_in <= 1'b0;
      end
      exp_sel = 1'b0;
      exp_lock = 1'b0;
      exp_warn = 2'h0;
      rd_all();
      d = $random(seed) | 32'h8F;
      d[6] = (p == 0);
      xfer(1'b1, 8'h00, d);
      rd_all();
      for (int k = 0; k < 4; k++) begin
        d = $random(seed);
        d[6] = (p != 0);
        d[5:4] = k[1:0];
        xfer(1'b1, 8'h00, d);
        rd_all();
      end
      xfer(1'b1, 8'h0C, $random(seed));
      rd_all();
      $display("pass %0d done", p);
    end
    tally_and_finish();
  end
endmodule

bind vts_trip_select_top vts_trip_select_assertions #(.WARNING_LEVELS(WARNING_LEVELS))
  i_vts_trip_select_assertions (.sys_clk_in, .rst_in, .hsel_in, .htrans_in, .hwrite_in,
  .hready_in, .hreadyout_out, .hresp_out, .detect_level_select_out,
  .warning_level_select_out, .detect_level_locked_out, .detect_trip_point_out,
  .warning_trip_point_out);
